// [rtio_defs.vh]
// Register offsets, field positions, reset values and timing for the relay/TTL port
`ifndef RTIO_DEFS_VH
`define RTIO_DEFS_VH

// Register byte offsets
`define RTIO_OFF_CTRL     8'h00
`define RTIO_OFF_RELAY    8'h04
`define RTIO_OFF_TTL_OUT  8'h08
`define RTIO_OFF_TTL_IN   8'h0c
`define RTIO_OFF_VCH_CFG  8'h10
`define RTIO_OFF_VCH1     8'h14
`define RTIO_OFF_VCH2     8'h18
`define RTIO_OFF_VCH3     8'h1c
`define RTIO_OFF_CONV     8'h20
`define RTIO_OFF_STATUS   8'h24

// Control register fields
`define RTIO_CTRL_OE      0
`define RTIO_CTRL_TTL_DIR 1

// Virtual channel config: bit n = channel n+1 is an input (follows)
`define RTIO_VCFG_IN_LSB  0
`define RTIO_VCFG_SRC_LSB 4

// Reset values
`define RTIO_RST_RELAY    4'h0
`define RTIO_RST_TTL      8'h00
`define RTIO_RST_VCH      16'h0000

// AXI responses
`define RTIO_RESP_OKAY    2'b00
`define RTIO_RESP_SLVERR  2'b10

// Conversion period in ns and derived cycle count at 50 ns clock
`define RTIO_CONV_NS      100000
`define RTIO_CLK_NS       50
`define RTIO_CONV_CYC     (`RTIO_CONV_NS / `RTIO_CLK_NS)

`endif

// [rtio_sync.v]
// Three-stage input synchroniser with agreement filter for TTL pins
`timescale 1ns/1ns
`default_nettype none

module rtio_sync #(
   parameter W = 8
) (
   input  wire         clk,      // System clock
   input  wire         rst_n,    // Synchronous reset, active low
   input  wire         ce,       // Clock enable
   input  wire [W-1:0] din,      // Asynchronous pin levels
   output reg  [W-1:0] dout_ff   // Filtered synchronous levels
);

   reg [W-1:0] s1_ff;
   reg [W-1:0] s2_ff;
   reg [W-1:0] s3_ff;

   // ----------------------------------------------------------------
   // Chain: only stage two reads stage one
   // ----------------------------------------------------------------
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         s1_ff   <= {W{1'b0}};
         s2_ff   <= {W{1'b0}};
         s3_ff   <= {W{1'b0}};
         dout_ff <= {W{1'b0}};
      end
      else if (ce)
      begin
         s1_ff <= din;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         // Change counts only once stages two and three agree
         dout_ff <= (s2_ff & ~(s2_ff ^ s3_ff)) |
                    (dout_ff & (s2_ff ^ s3_ff));
      end
   end

endmodule // rtio_sync

`default_nettype wire

// [rtio_port.v]
// Relay and TTL I/O port with virtual channels behind an AXI4-Lite slave
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "rtio_defs.vh"

module rtio_port #(
   parameter VW       = 16,              // Virtual channel width
   parameter CONV_CYC = `RTIO_CONV_CYC   // Cycles between conversions
) (
   input  wire          clk,            // System clock, 20 MHz
   input  wire          rst_n,          // Synchronous reset, active low
   input  wire          ce,             // Clock enable, freezes all state
   // AXI4-Lite slave
   input  wire [7:0]    s_awaddr,       // Write address
   input  wire          s_awvalid,      // Write address valid
   output reg           s_awready,      // Write address ready
   input  wire [31:0]   s_wdata,        // Write data
   input  wire [3:0]    s_wstrb,        // Write byte strobes
   input  wire          s_wvalid,       // Write data valid
   output reg           s_wready,       // Write data ready
   output reg  [1:0]    s_bresp,        // Write response
   output reg           s_bvalid,       // Write response valid
   input  wire          s_bready,       // Write response ready
   input  wire [7:0]    s_araddr,       // Read address
   input  wire          s_arvalid,      // Read address valid
   output reg           s_arready,      // Read address ready
   output reg  [31:0]   s_rdata,        // Read data
   output reg  [1:0]    s_rresp,        // Read response
   output reg           s_rvalid,       // Read data valid
   input  wire          s_rready,       // Read data ready
   // Relays and TTL pins
   output reg  [3:0]    relay_drive,    // Relay coil drive, A in bit 0
   input  wire [7:0]    ttl_in,         // TTL pin levels
   output reg  [7:0]    ttl_out,        // TTL pin drive values
   output reg  [7:0]    ttl_oe,         // TTL pin output enables
   // Virtual channel feed
   input  wire [VW-1:0] follow_src0,    // Followable channel 0
   input  wire [VW-1:0] follow_src1,    // Followable channel 1
   input  wire [VW-1:0] pid_out1,       // Feedback result, channel one
   input  wire [VW-1:0] pid_out2,       // Feedback result, channel two
   input  wire [VW-1:0] pid_out3,       // Feedback result, channel three
   output reg           conv_tick,      // Conversion event pulse
   output reg           pid_run         // Feedback loops may run
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   reg          oe_ff;
   reg          ttl_dir_ff;                // 1 = output
   reg [3:0]    relay_ff;
   reg [7:0]    ttl_wr_ff;
   reg [5:0]    vcfg_ff;                   // [2:0] input, [5:3] source
   reg [VW-1:0] vpend_ff [0:2];            // Written, not yet effective
   reg [VW-1:0] vch_ff   [0:2];            // Effective values
   reg [2:0]    vdirty_ff;
   reg [31:0]   conv_cnt_ff;
   reg [31:0]   conv_num_ff;
   reg          aw_got_ff;
   reg          w_got_ff;
   reg [7:0]    awaddr_ff;
   reg [31:0]   wdata_ff;
   reg [3:0]    wstrb_ff;
   wire [7:0]   ttl_sync;
   integer      i;

   // Synchronised TTL pins
   rtio_sync #(.W(8)) u_sync (
      .clk     (clk),
      .rst_n   (rst_n),
      .ce      (ce),
      .din     (ttl_in),
      .dout_ff (ttl_sync)
   );

   // Merge a written word with its byte strobes
   function [31:0] strb_merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  st;
      integer k;
      begin
         strb_merge = old;
         for (k = 0; k < 4; k = k + 1)
            if (st[k])
               strb_merge[k*8 +: 8] = nw[k*8 +: 8];
      end
   endfunction

   // Select one followable source
   function [VW-1:0] src_pick;
      input sel;
      begin
         src_pick = sel ? follow_src1 : follow_src0;
      end
   endfunction

   // Virtual channel index from its address: 14/18/1c give 0/1/2
   // The two-bit sum wraps on purpose, so no compare chain is needed
   function [1:0] vch_idx;
      input [7:0] addr;
      begin
         vch_idx = addr[3:2] + 2'd3;
      end
   endfunction

   // Whole-port TTL value as seen by software
   wire [7:0] ttl_value = ttl_dir_ff ? ttl_wr_ff : ttl_sync;

   wire        conv_now = (conv_cnt_ff == CONV_CYC - 1);
   wire        wr_go    = aw_got_ff && w_got_ff && !s_bvalid;
   wire [31:0] wm       = strb_merge(32'h0000_0000, wdata_ff, wstrb_ff);

   // Pending virtual word merged with the strobes; only the low VW
   // bits are kept, the upper bytes of a wide write are dropped
   wire [31:0] vmerge   = strb_merge({{(32-VW){1'b0}},
                                      vpend_ff[vch_idx(awaddr_ff)]},
                                     wdata_ff, wstrb_ff);

   // ----------------------------------------------------------------
   // AXI write channel: address and data in either order
   // ----------------------------------------------------------------
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         s_awready <= 1'b0;
         s_wready  <= 1'b0;
         s_bvalid  <= 1'b0;
         s_bresp   <= `RTIO_RESP_OKAY;
         aw_got_ff <= 1'b0;
         w_got_ff  <= 1'b0;
         awaddr_ff <= 8'h00;
         wdata_ff  <= 32'h0000_0000;
         wstrb_ff  <= 4'h0;
      end
      else if (ce)
      begin
         s_awready <= !aw_got_ff && !s_awready && s_awvalid;
         s_wready  <= !w_got_ff && !s_wready && s_wvalid;
         if (s_awvalid && s_awready)
         begin
            aw_got_ff <= 1'b1;
            awaddr_ff <= s_awaddr;
         end
         if (s_wvalid && s_wready)
         begin
            w_got_ff <= 1'b1;
            wdata_ff <= s_wdata;
            wstrb_ff <= s_wstrb;
         end
         if (wr_go)
         begin
            aw_got_ff <= 1'b0;
            w_got_ff  <= 1'b0;
            s_bvalid  <= 1'b1;
            case (awaddr_ff)
               `RTIO_OFF_CTRL, `RTIO_OFF_RELAY, `RTIO_OFF_TTL_OUT,
               `RTIO_OFF_VCH_CFG, `RTIO_OFF_VCH1, `RTIO_OFF_VCH2,
               `RTIO_OFF_VCH3:
                  s_bresp <= `RTIO_RESP_OKAY;
               default:
                  s_bresp <= `RTIO_RESP_SLVERR;
            endcase
         end
         else if (s_bvalid && s_bready)
            s_bvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Register writes and conversion timing
   // ----------------------------------------------------------------
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         oe_ff       <= 1'b0;
         ttl_dir_ff  <= 1'b0;
         relay_ff    <= `RTIO_RST_RELAY;
         ttl_wr_ff   <= `RTIO_RST_TTL;
         vcfg_ff     <= 6'h00;
         vdirty_ff   <= 3'h0;
         conv_cnt_ff <= 32'h0000_0000;
         conv_num_ff <= 32'h0000_0000;
         for (i = 0; i < 3; i = i + 1)
         begin
            vpend_ff[i] <= `RTIO_RST_VCH;
            vch_ff[i]   <= `RTIO_RST_VCH;
         end
      end
      else if (ce)
      begin
         // Free-running conversion timer
         if (conv_now)
         begin
            conv_cnt_ff <= 32'h0000_0000;
            conv_num_ff <= conv_num_ff + 32'h0000_0001;
         end
         else
            conv_cnt_ff <= conv_cnt_ff + 32'h0000_0001;

         // Virtual values update only at the conversion event
         if (conv_now)
         begin
            for (i = 0; i < 3; i = i + 1)
            begin
               if (vcfg_ff[i])
                  vch_ff[i] <= src_pick(vcfg_ff[3+i]);
               else if (vdirty_ff[i])
                  vch_ff[i] <= vpend_ff[i];
               else if (oe_ff)
                  vch_ff[i] <= (i == 0) ? pid_out1 :
                               (i == 1) ? pid_out2 : pid_out3;
               // Output enable off: value simply holds
            end
            vdirty_ff <= 3'h0;
         end

         if (wr_go)
         begin
            case (awaddr_ff)
               `RTIO_OFF_CTRL:
               begin
                  if (wstrb_ff[0])
                  begin
                     oe_ff      <= wm[`RTIO_CTRL_OE];
                     ttl_dir_ff <= wm[`RTIO_CTRL_TTL_DIR];
                  end
               end
               `RTIO_OFF_RELAY:
                  if (wstrb_ff[0])
                     relay_ff <= wm[3:0];
               `RTIO_OFF_TTL_OUT:
                  if (wstrb_ff[0])
                     ttl_wr_ff <= wm[7:0];
               `RTIO_OFF_VCH_CFG:
                  if (wstrb_ff[0])
                     vcfg_ff <= {wm[6:4], wm[2:0]};
               `RTIO_OFF_VCH1, `RTIO_OFF_VCH2, `RTIO_OFF_VCH3:
               begin
                  vpend_ff[vch_idx(awaddr_ff)] <= vmerge[VW-1:0];
                  // A write landing on a conversion edge still counts
                  vdirty_ff[vch_idx(awaddr_ff)] <= 1'b1;
               end
               default:
                  ;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // AXI read channel
   // ----------------------------------------------------------------
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         s_arready <= 1'b0;
         s_rvalid  <= 1'b0;
         s_rdata   <= 32'h0000_0000;
         s_rresp   <= `RTIO_RESP_OKAY;
      end
      else if (ce)
      begin
         s_arready <= !s_arready && !s_rvalid && s_arvalid;
         if (s_arvalid && s_arready)
         begin
            s_rvalid <= 1'b1;
            s_rresp  <= `RTIO_RESP_OKAY;
            case (s_araddr)
               `RTIO_OFF_CTRL:
                  s_rdata <= {30'h0, ttl_dir_ff, oe_ff};
               `RTIO_OFF_RELAY:
                  s_rdata <= {28'h0, relay_ff & {4{oe_ff}}};
               `RTIO_OFF_TTL_OUT:
                  s_rdata <= {24'h0, ttl_wr_ff};
               `RTIO_OFF_TTL_IN:
                  s_rdata <= {24'h0, ttl_value};
               `RTIO_OFF_VCH_CFG:
                  s_rdata <= {25'h0, vcfg_ff[5:3], 1'b0, vcfg_ff[2:0]};
               `RTIO_OFF_VCH1:
                  s_rdata <= {{(32-VW){1'b0}}, vch_ff[0]};
               `RTIO_OFF_VCH2:
                  s_rdata <= {{(32-VW){1'b0}}, vch_ff[1]};
               `RTIO_OFF_VCH3:
                  s_rdata <= {{(32-VW){1'b0}}, vch_ff[2]};
               `RTIO_OFF_CONV:
                  s_rdata <= conv_num_ff;
               `RTIO_OFF_STATUS:
                  s_rdata <= {29'h0, vdirty_ff};
               default:
               begin
                  s_rdata <= 32'h0000_0000;
                  s_rresp <= `RTIO_RESP_SLVERR;
               end
            endcase
         end
         else if (s_rvalid && s_rready)
            s_rvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Pin outputs, all registered
   // ----------------------------------------------------------------
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         relay_drive <= 4'h0;
         ttl_out     <= 8'h00;
         ttl_oe      <= 8'h00;
         conv_tick   <= 1'b0;
         pid_run     <= 1'b0;
      end
      else if (ce)
      begin
         relay_drive <= relay_ff & {4{oe_ff}};
         ttl_out     <= ttl_wr_ff;
         ttl_oe      <= {8{ttl_dir_ff}};
         conv_tick   <= conv_now;
         pid_run     <= oe_ff;
      end
   end

endmodule // rtio_port

`default_nettype wire

// [rtio_port_assertions.sv]
// Concurrent checks on the relay and TTL port pins and bus
`timescale 1ns/1ns
`default_nettype none

module rtio_port_assertions #(
   parameter CONV_CYC = 8                  // Cycles between conversions
) (
   input wire logic        clk,            // System clock
   input wire logic        rst_n,          // Reset, active low
   input wire logic        s_bvalid,       // Write response valid
   input wire logic        s_bready,       // Write response ready
   input wire logic [1:0]  s_bresp,        // Write response
   input wire logic        s_rvalid,       // Read data valid
   input wire logic        s_rready,       // Read data ready
   input wire logic [31:0] s_rdata,        // Read data
   input wire logic [1:0]  s_rresp,        // Read response
   input wire logic        s_arready,      // Read address ready
   input wire logic [3:0]  relay_drive,    // Relay coil drive
   input wire logic [7:0]  ttl_oe,         // TTL output enables
   input wire logic        conv_tick,      // Conversion pulse
   input wire logic        pid_run         // Feedback loops may run
);
   logic [15:0] gap_ff;
   logic        seen_ff;

   // Cycles since the last pulse; first gap after reset is not judged
   always_ff @(posedge clk)
   begin
      gap_ff  <= (!rst_n || conv_tick) ? 16'h0000 : gap_ff + 16'h0001;
      seen_ff <= rst_n && (seen_ff || conv_tick);
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   ttl_dir_a: assert property (ttl_oe == 8'h00 || ttl_oe == 8'hff)
      else $error("TTL enables differ between lines");
   relay_gate_a: assert property (relay_drive != 4'h0 |-> pid_run)
      else $error("Relay drive without output enable");
   relay_upd_a: assert property ($changed(relay_drive) |-> $past(s_bvalid))
      else $error("Relay drive moved without a write");
   conv_gap_a: assert property (conv_tick && seen_ff |-> gap_ff == CONV_CYC - 1)
      else $error("Conversion spacing wrong");
   bresp_hold_a: assert property (s_bvalid && !s_bready |=>
      s_bvalid && $stable(s_bresp)) else $error("Write response dropped");
   rdata_hold_a: assert property (s_rvalid && !s_rready |=>
      s_rvalid && $stable(s_rdata)) else $error("Read data dropped");
   ar_refuse_a: assert property (s_rvalid |-> !s_arready)
      else $error("Read address taken while data pending");
   err_zero_a: assert property (s_rvalid && s_rresp == 2'h2 |-> s_rdata == 0)
      else $error("Error read carries data");
   reset_clear_a: assert property (disable iff (1'h0) !rst_n |=>
      relay_drive == 4'h0 && ttl_oe == 8'h00 && !pid_run)
      else $error("Reset left outputs active");
endmodule // rtio_port_assertions
`default_nettype wire

// [rtio_port_ext.sv]
// Model of the equipment wired to the TTL lines
`timescale 1ns/1ns
`default_nettype none

module rtio_port_ext (
   input  wire logic [7:0] ttl_out,  // Port drive values
   input  wire logic [7:0] ttl_oe,   // Port output enables
   input  wire logic [7:0] drv,      // Level the equipment applies
   output wire logic [7:0] ttl_in    // Resolved line levels
);
   // Equipment lets go of a line once the port drives it, so a port
   // that turned round is never fought
   assign ttl_in = (ttl_oe & ttl_out) | (~ttl_oe & drv);
endmodule // rtio_port_ext
`default_nettype wire

// [rtio_port_tb.sv]
// Self-checking bench for the relay and TTL port
`timescale 1ns/1ns
`default_nettype none
`include "rtio_defs.vh"

module rtio_port_tb;
   localparam int CV = 40;
   logic        clk = 1'h0, rst_n = 1'h0, ce = 1'h1;
   logic        s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0;
   logic        s_arvalid = 1'h0, s_rready = 1'h0;
   logic [7:0]  s_awaddr = 8'h00, s_araddr = 8'h00, drv = 8'h00;
   logic [31:0] s_wdata = 32'h0;
   logic [3:0]  s_wstrb = 4'hf;
   logic [15:0] follow_src0 = 16'h0, follow_src1 = 16'h0;
   logic [15:0] pid_out1 = 16'h0, pid_out2 = 16'h0, pid_out3 = 16'h0;
   wire logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   wire logic [1:0]  s_bresp, s_rresp;
   wire logic [31:0] s_rdata;
   wire logic [3:0]  relay_drive;
   wire logic [7:0]  ttl_in, ttl_out, ttl_oe;
   wire logic        conv_tick, pid_run;
   int miscompares = 0, compares = 0, cyc = 0;

   rtio_port #(.CONV_CYC(CV)) rtio_port_inst (.clk, .rst_n, .ce, .s_awaddr,
      .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
      .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
      .s_rdata, .s_rresp, .s_rvalid, .s_rready, .relay_drive, .ttl_in,
      .ttl_out, .ttl_oe, .follow_src0, .follow_src1, .pid_out1, .pid_out2,
      .pid_out3, .conv_tick, .pid_run);
   rtio_port_ext rtio_port_ext_inst (.ttl_out, .ttl_oe, .drv, .ttl_in);

   // 20 MHz clock
   always #25 clk = ~clk;

   // Ceiling well above the several hundred cycles the tests need
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         miscompares++;
         summarize();
      end
   end

   // ---------------------------------------------------------------
   // Bus and compare tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // Address and data offered together, each dropped once taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         input logic [1:0] er = 2'h0);
      @(posedge clk);
      s_awaddr <= a;
      s_wdata <= d;
      s_awvalid <= 1'h1;
      s_wvalid <= 1'h1;
      s_bready <= 1'h1;
      do
      begin
         @(posedge clk);
         if (s_awready) s_awvalid <= 1'h0;
         if (s_wready) s_wvalid <= 1'h0;
      end
      while (s_bvalid !== 1'h1);
      s_bready <= 1'h0;
      chk({30'h0, s_bresp}, {30'h0, er});
   endtask

   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
                         input logic [1:0] er = 2'h0);
      @(posedge clk);
      s_araddr <= a;
      s_arvalid <= 1'h1;
      s_rready <= 1'h1;
      do
      begin
         @(posedge clk);
         if (s_arready) s_arvalid <= 1'h0;
      end
      while (s_rvalid !== 1'h1);
      s_rready <= 1'h0;
      chk(s_rdata, ed);
      chk({30'h0, s_rresp}, {30'h0, er});
   endtask

   // Write, let the coil drive settle, compare it
   task automatic wr_relay(input logic [7:0] a, input logic [31:0] d,
                           input logic [3:0] exp);
      axi_wr(a, d);
      repeat (2) @(posedge clk);
      chk({28'h0, relay_drive}, {28'h0, exp});
   endtask

   task automatic tick(input int k);
      repeat (k)
      begin
         @(posedge clk);
         while (conv_tick !== 1'h1) @(posedge clk);
      end
   endtask

   task automatic summarize;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------
   initial
   begin
      repeat (6) @(posedge clk);
      rst_n <= 1'h1;
      axi_rd(`RTIO_OFF_CTRL, 32'h0);
      axi_rd(`RTIO_OFF_RELAY, 32'h0);
      chk({24'h0, ttl_oe}, 32'h0);
      $display("test reset done");
      // Mask alone must not pull a relay in
      wr_relay(`RTIO_OFF_RELAY, 32'h6, 4'h0);
      wr_relay(`RTIO_OFF_CTRL, 32'h1, 4'h6);
      axi_rd(`RTIO_OFF_RELAY, 32'h6);
      wr_relay(`RTIO_OFF_RELAY, 32'h9, 4'h9);
      // No byte strobe: the mask must stay as it was
      s_wstrb <= 4'h0;
      wr_relay(`RTIO_OFF_RELAY, 32'h3, 4'h9);
      s_wstrb <= 4'hf;
      wr_relay(`RTIO_OFF_CTRL, 32'h0, 4'h0);
      $display("test relays done");
      // One line high at a time gives each weight
      for (int n = 0; n < 8; n++)
      begin
         drv <= 8'h01 << n;
         repeat (10) @(posedge clk);
         axi_rd(`RTIO_OFF_TTL_IN, 32'h1 << n);
      end
      axi_wr(`RTIO_OFF_TTL_OUT, 32'ha5);
      axi_wr(`RTIO_OFF_CTRL, 32'h2);
      repeat (2) @(posedge clk);
      chk({ttl_oe, 16'h0, ttl_out}, 32'hff0000a5);
      axi_rd(`RTIO_OFF_TTL_OUT, 32'ha5);
      axi_rd(`RTIO_OFF_TTL_IN, 32'ha5);
      axi_wr(`RTIO_OFF_CTRL, 32'h0);
      $display("test ttl done");
      // Write just after a conversion so the readback is early
      tick(1);
      axi_wr(`RTIO_OFF_VCH1, 32'h1234);
      axi_rd(`RTIO_OFF_VCH1, 32'h0);
      axi_rd(`RTIO_OFF_STATUS, 32'h1);
      tick(1);
      axi_rd(`RTIO_OFF_VCH1, 32'h1234);
      axi_rd(`RTIO_OFF_STATUS, 32'h0);
      pid_out2 <= 16'habcd;
      axi_wr(`RTIO_OFF_CTRL, 32'h1);
      tick(2);
      axi_rd(`RTIO_OFF_VCH2, 32'habcd);
      chk({31'h0, pid_run}, 32'h1);
      axi_wr(`RTIO_OFF_CTRL, 32'h0);
      pid_out2 <= 16'h1111;
      tick(2);
      axi_rd(`RTIO_OFF_VCH2, 32'habcd);
      chk({31'h0, pid_run}, 32'h0);
      follow_src0 <= 16'h2222;
      follow_src1 <= 16'h5555;
      axi_wr(`RTIO_OFF_VCH_CFG, 32'h45);
      axi_rd(`RTIO_OFF_VCH_CFG, 32'h45);
      tick(2);
      axi_rd(`RTIO_OFF_VCH1, 32'h2222);
      axi_rd(`RTIO_OFF_VCH3, 32'h5555);
      $display("test virtual done");
      // Reset in mid-run with relays pulled in and the port driving
      axi_wr(`RTIO_OFF_CTRL, 32'h3);
      repeat (2) @(posedge clk);
      chk({ttl_oe, 20'h0, relay_drive}, 32'hff000009);
      rst_n <= 1'h0;
      repeat (6) @(posedge clk);
      rst_n <= 1'h1;
      chk({ttl_oe, 20'h0, relay_drive}, 32'h0);
      axi_rd(`RTIO_OFF_CTRL, 32'h0);
      axi_rd(`RTIO_OFF_RELAY, 32'h0);
      $display("test midrun reset done");
      axi_wr(8'h40, 32'h1, `RTIO_RESP_SLVERR);
      axi_rd(8'h40, 32'h0, `RTIO_RESP_SLVERR);
      $display("test unmapped done");
      summarize();
   end
endmodule // rtio_port_tb

bind rtio_port rtio_port_assertions #(.CONV_CYC(CONV_CYC))
   rtio_port_assertions_inst (.clk, .rst_n, .s_bvalid, .s_bready, .s_bresp,
   .s_rvalid, .s_rready, .s_rdata, .s_rresp, .s_arready, .relay_drive,
   .ttl_oe, .conv_tick, .pid_run);
`default_nettype wire
